/* rtl/tlb_inval_pkg.sv */
package tlb_inval_pkg;

   // Register byte offsets
   localparam logic [7:0] CFG_OFFSET    = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;

   // Control/capability field positions in the config register
   localparam int HOST_EXT_POS = 0;
   localparam int HYP_POS      = 1;
   localparam int REALM_POS    = 2;
   localparam int SEC_S2_POS   = 3;
   localparam int NS_S2_POS    = 4;
   localparam int STAGE1_POS   = 5;
   localparam int CFG_W        = 6;

   // Stage 1 and hypervisor support on, everything else off
   localparam logic [CFG_W-1:0] CFG_RESET = 6'h22;

   // Status register field positions
   localparam int ILL_CNT_POS = 0;
   localparam int VALID_CNT_POS = 8;

   localparam logic [7:0] ILL_CNT_RESET = 8'h00;

   typedef enum logic [3:0] {
      kernel_inval_all_cmd          = 4'h0,
      kernel_inval_by_tag_cmd       = 4'h1,
      kernel_inval_addr_alltags_cmd = 4'h2,
      kernel_inval_addr_cmd         = 4'h3,
      monitor_inval_all_cmd         = 4'h4,
      monitor_inval_addr_cmd        = 4'h5,
      hyp_inval_all_cmd             = 4'h6,
      hyp_inval_addr_cmd            = 4'h7,
      hyp_inval_addr_alltags_cmd    = 4'h8,
      hyp_inval_by_tag_cmd          = 4'h9
   } cmd_type;

   typedef enum logic [2:0] {
      regime_ns_kernel    = 3'h0,
      regime_sec_kernel   = 3'h1,
      regime_hyp          = 3'h2,
      regime_host_ext_hyp = 3'h3,
      regime_monitor      = 3'h4
   } translation_regime_tag_type;

endpackage

/* rtl/tlb_stage1_inval.sv */
`timescale 1ns/100ps
// How it works
// RULE_01 - Nonsecure kernel all: kernel entries of tag
// RULE_02 - Secure all, no stage 2: every secure kernel entry
// RULE_03 - Secure all with stage 2: kernel entries of tag
// RULE_04 - Nonsecure by tag: nonglobal, tag and machine match
// RULE_05 - Secure by tag, no stage 2: tag only
// RULE_06 - Secure by tag with stage 2: both tags
// RULE_07 - Nonsecure address all tags: address within machine
// RULE_08 - Secure address all tags: machine only with stage 2
// RULE_09 - Nonsecure by address: tag match or global
// RULE_10 - Secure by address: machine only with stage 2
// RULE_11 - Leaf flag limits hits to last level
// RULE_12 - Monitor commands hit monitor entries, all or address
// RULE_13 - Monitor commands illegal on nonsecure queue
// RULE_14 - Monitor commands illegal when realm extension present
// RULE_15 - Hypervisor all hits plain and host-extended entries
// RULE_16 - Hypervisor commands illegal without hypervisor support
// RULE_17 - Hypervisor commands ignore the issuing queue
// RULE_18 - Host extension on: host-extended, tag or global
// RULE_19 - Host extension off: plain hypervisor by address
// RULE_20 - Hypervisor address all tags follows host extension
// RULE_21 - Software keeps host extension known while queued
// RULE_22 - Hypervisor by tag: nonglobal host-extended only
// RULE_23 - Stage 2 only: every command illegal
// RULE_24 - Machine tag compared only with stage 2
// RULE_25 - Entries outside scope stay valid
module tlb_stage1_inval #(
   parameter int ENTRIES = 8,
   parameter int MTAG_W  = 16,
   parameter int STAG_W  = 16,
   parameter int PAGE_W  = 40,
   parameter int IDX_W   = $clog2(ENTRIES)
) (
   input  wire logic                                      core_clk,
   input  wire logic                                      sys_rst,
   // Wishbone classic slave
   input  wire logic                                      wb_cyc_i,
   input  wire logic                                      wb_stb_i,
   input  wire logic                                      wb_we_i,
   input  wire logic [7:0]                                wb_adr_i,
   input  wire logic [3:0]                                wb_sel_i,
   input  wire logic [31:0]                               wb_dat_i,
   output logic                                           wb_ack_o,
   output logic      [31:0]                               wb_dat_o,
   // Command from either queue
   input  wire logic                                      cmd_valid,
   input  wire tlb_inval_pkg::cmd_type                    cmd_op,
   input  wire logic                                      cmd_secure,
   input  wire logic [MTAG_W-1:0]                         cmd_mtag,
   input  wire logic [STAG_W-1:0]                         cmd_stag,
   input  wire logic [PAGE_W-1:0]                         cmd_page,
   input  wire logic                                      cmd_leaf,
   output logic                                           cmd_done,
   output logic                                           cmd_illegal,
   // Entry fill from the walker
   input  wire logic                                      fill_valid,
   input  wire logic [IDX_W-1:0]                          fill_index,
   input  wire tlb_inval_pkg::translation_regime_tag_type fill_regime,
   input  wire logic                                      fill_global,
   input  wire logic [MTAG_W-1:0]                         fill_mtag,
   input  wire logic [STAG_W-1:0]                         fill_stag,
   input  wire logic [PAGE_W-1:0]                         fill_page,
   input  wire logic                                      fill_leaf,
   output logic      [ENTRIES-1:0]                        entry_valid
);

   logic [tlb_inval_pkg::CFG_W-1:0]        cfg_q;
   logic [ENTRIES-1:0]                     valid_q;
   logic [ENTRIES-1:0]                     valid_d;
   tlb_inval_pkg::translation_regime_tag_type rg_q [ENTRIES];
   logic [ENTRIES-1:0]                     glb_q;
   logic [ENTRIES-1:0]                     leaf_q;
   logic [MTAG_W-1:0]                      mtag_q [ENTRIES];
   logic [STAG_W-1:0]                      stag_q [ENTRIES];
   logic [PAGE_W-1:0]                      page_q [ENTRIES];
   logic [ENTRIES-1:0]                     hit;
   logic [ENTRIES-1:0]                     fill_oh;
   logic [ENTRIES-1:0]                     kern_m;
   logic [ENTRIES-1:0]                     vm_m;
   logic [ENTRIES-1:0]                     as_m;
   logic [ENTRIES-1:0]                     ad_m;
   logic                                   illegal;
   logic                                   apply;
   logic                                   s2_here;
   logic                                   host_ext;
   tlb_inval_pkg::translation_regime_tag_type kern_rg;
   logic                                   done_q;
   logic                                   ill_q;
   logic [7:0]                             ill_cnt_q;
   logic [7:0]                             valid_cnt;
   logic                                   ack_q;
   logic [31:0]                            rdat_q;
   logic                                   wb_req;

   assign wb_ack_o    = ack_q;
   assign wb_dat_o    = rdat_q;
   assign cmd_done    = done_q;
   assign cmd_illegal = ill_q;
   assign entry_valid = valid_q;

   assign host_ext = cfg_q[tlb_inval_pkg::HOST_EXT_POS];
   // Stage 2 presence for the queue the command came from
   assign s2_here = cmd_secure ? cfg_q[tlb_inval_pkg::SEC_S2_POS]
                               : cfg_q[tlb_inval_pkg::NS_S2_POS];
   assign kern_rg = cmd_secure ? tlb_inval_pkg::regime_sec_kernel
                               : tlb_inval_pkg::regime_ns_kernel;
   assign apply   = cmd_valid && !illegal;

   // Legality of the command
   always_comb begin
      illegal = 1'b0;
      unique case (cmd_op)
         tlb_inval_pkg::kernel_inval_all_cmd,
         tlb_inval_pkg::kernel_inval_by_tag_cmd,
         tlb_inval_pkg::kernel_inval_addr_alltags_cmd,
         tlb_inval_pkg::kernel_inval_addr_cmd: begin
            illegal = 1'b0;
         end
         tlb_inval_pkg::monitor_inval_all_cmd,
         tlb_inval_pkg::monitor_inval_addr_cmd: begin
            illegal = !cmd_secure || cfg_q[tlb_inval_pkg::REALM_POS]; // see RULE_13 see RULE_14
         end
         tlb_inval_pkg::hyp_inval_all_cmd,
         tlb_inval_pkg::hyp_inval_addr_cmd,
         tlb_inval_pkg::hyp_inval_addr_alltags_cmd,
         tlb_inval_pkg::hyp_inval_by_tag_cmd: begin
            illegal = !cfg_q[tlb_inval_pkg::HYP_POS]; // see RULE_16
         end
         default: begin
            illegal = 1'b1;
         end
      endcase
      if (!cfg_q[tlb_inval_pkg::STAGE1_POS]) begin
         illegal = 1'b1; // see RULE_23
      end
   end

   // Per-entry scope match
   always_comb begin
      for (int i = 0; i < ENTRIES; i++) begin
         kern_m[i] = rg_q[i] == kern_rg;
         vm_m[i]   = !s2_here || mtag_q[i] == cmd_mtag; // see RULE_24
         as_m[i]   = stag_q[i] == cmd_stag;
         // Leaf-only requests spare cached intermediate table entries
         ad_m[i]   = page_q[i] == cmd_page && (!cmd_leaf || leaf_q[i]); // see RULE_11
         unique case (cmd_op)
            tlb_inval_pkg::kernel_inval_all_cmd: begin
               hit[i] = kern_m[i] && vm_m[i]; // see RULE_01 see RULE_02 see RULE_03
            end
            tlb_inval_pkg::kernel_inval_by_tag_cmd: begin
               hit[i] = kern_m[i] && vm_m[i] && as_m[i]
                     && !glb_q[i]; // see RULE_04 see RULE_05 see RULE_06
            end
            tlb_inval_pkg::kernel_inval_addr_alltags_cmd: begin
               hit[i] = kern_m[i] && vm_m[i] && ad_m[i]; // see RULE_07 see RULE_08
            end
            tlb_inval_pkg::kernel_inval_addr_cmd: begin
               hit[i] = kern_m[i] && vm_m[i] && ad_m[i]
                     && (as_m[i] || glb_q[i]); // see RULE_09 see RULE_10
            end
            tlb_inval_pkg::monitor_inval_all_cmd: begin
               hit[i] = rg_q[i] == tlb_inval_pkg::regime_monitor; // see RULE_12
            end
            tlb_inval_pkg::monitor_inval_addr_cmd: begin
               hit[i] = rg_q[i] == tlb_inval_pkg::regime_monitor && ad_m[i]; // see RULE_12
            end
            // Hypervisor scopes never look at the queue
            tlb_inval_pkg::hyp_inval_all_cmd: begin
               hit[i] = rg_q[i] == tlb_inval_pkg::regime_hyp
                     || rg_q[i] == tlb_inval_pkg::regime_host_ext_hyp; // see RULE_15 see RULE_17
            end
            tlb_inval_pkg::hyp_inval_addr_cmd: begin
               if (host_ext) begin
                  hit[i] = rg_q[i] == tlb_inval_pkg::regime_host_ext_hyp
                        && ad_m[i] && (as_m[i] || glb_q[i]); // see RULE_18
               end else begin
                  hit[i] = rg_q[i] == tlb_inval_pkg::regime_hyp && ad_m[i]; // see RULE_19
               end
            end
            tlb_inval_pkg::hyp_inval_addr_alltags_cmd: begin
               hit[i] = ad_m[i] && rg_q[i] == (host_ext ? tlb_inval_pkg::regime_host_ext_hyp
                                                      : tlb_inval_pkg::regime_hyp); // see RULE_20
            end
            tlb_inval_pkg::hyp_inval_by_tag_cmd: begin
               hit[i] = rg_q[i] == tlb_inval_pkg::regime_host_ext_hyp
                     && as_m[i] && !glb_q[i]; // see RULE_22
            end
            default: begin
               hit[i] = 1'b0;
            end
         endcase
      end
   end

   always_comb begin
      fill_oh = '0;
      if (fill_valid) begin
         fill_oh[fill_index] = 1'b1;
      end
      // A fill in the same cycle lands after the invalidation
      valid_d = (valid_q & ~(apply ? hit : '0)) | fill_oh; // see RULE_25
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         valid_q <= '0;
      end else begin
         valid_q <= valid_d;
      end
   end

   // Entry payload carries no reset; valid_q guards it
   always_ff @(posedge core_clk) begin
      if (fill_valid) begin
         rg_q[fill_index]   <= fill_regime;
         glb_q[fill_index]  <= fill_global;
         leaf_q[fill_index] <= fill_leaf;
         mtag_q[fill_index] <= fill_mtag;
         stag_q[fill_index] <= fill_stag;
         page_q[fill_index] <= fill_page;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         done_q    <= 1'b0;
         ill_q     <= 1'b0;
         ill_cnt_q <= tlb_inval_pkg::ILL_CNT_RESET;
      end else begin
         done_q <= cmd_valid;
         ill_q  <= cmd_valid && illegal;
         if (cmd_valid && illegal) begin
            ill_cnt_q <= ill_cnt_q + 8'h01;
         end
      end
   end

   always_comb begin
      valid_cnt = 8'h00;
      for (int i = 0; i < ENTRIES; i++) begin
         valid_cnt = valid_cnt + {7'h00, valid_q[i]};
      end
   end

   // Wishbone: one wait state, ack drops the cycle after
   assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
         cfg_q  <= tlb_inval_pkg::CFG_RESET;
      end else begin
         ack_q  <= wb_req;
         rdat_q <= 32'h0000_0000;
         // Commit on the edge where the master sees ack, so an abandoned cycle writes nothing
         if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0]
             && wb_adr_i == tlb_inval_pkg::CFG_OFFSET) begin
            cfg_q <= wb_dat_i[tlb_inval_pkg::CFG_W-1:0];
         end
         if (wb_req && !wb_we_i) begin
            if (wb_adr_i == tlb_inval_pkg::CFG_OFFSET) begin
               rdat_q <= {26'h000_0000, cfg_q};
            end else if (wb_adr_i == tlb_inval_pkg::STATUS_OFFSET) begin
               rdat_q <= {16'h0000, valid_cnt, ill_cnt_q};
            end
         end
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence monitor_cmd_s;
      cmd_valid && (cmd_op == tlb_inval_pkg::monitor_inval_all_cmd
                 || cmd_op == tlb_inval_pkg::monitor_inval_addr_cmd);
   endsequence

   sequence refused_s;
      cmd_illegal && cmd_done;
   endsequence

   mon_ns_refused_a: assert property (monitor_cmd_s and !cmd_secure |=> refused_s) // see RULE_13
      else $error("monitor command on nonsecure queue not refused");

   realm_refused_a: assert property ( // see RULE_14
      monitor_cmd_s and cfg_q[tlb_inval_pkg::REALM_POS] |=> refused_s)
      else $error("monitor command accepted with realm extension");

   hyp_refused_a: assert property (cmd_valid && !cfg_q[tlb_inval_pkg::HYP_POS] // see RULE_16
      && cmd_op >= tlb_inval_pkg::hyp_inval_all_cmd
      && cmd_op <= tlb_inval_pkg::hyp_inval_by_tag_cmd |=> refused_s)
      else $error("hypervisor command accepted without support");

   s2_only_a: assert property ( // see RULE_23
      cmd_valid && !cfg_q[tlb_inval_pkg::STAGE1_POS] |=> refused_s)
      else $error("command accepted without stage 1");

   refused_frozen_a: assert property ( // see RULE_25
      cmd_valid && illegal && !fill_valid |=> entry_valid == $past(entry_valid))
      else $error("refused command changed entries");

   for (genvar g = 0; g < ENTRIES; g++) begin : g_chk
      logic no_fill;
      assign no_fill = !(fill_valid && fill_index == IDX_W'(g));

      keep_entry_a: assert property ( // see RULE_25
         valid_q[g] && !(apply && hit[g]) && no_fill |=> entry_valid[g])
         else $error("out of scope entry lost");

      ns_kall_a: assert property (cmd_valid && no_fill // see RULE_01
         && cmd_op == tlb_inval_pkg::kernel_inval_all_cmd && !cmd_secure
         && cfg_q[tlb_inval_pkg::STAGE1_POS]
         && rg_q[g] == tlb_inval_pkg::regime_ns_kernel
         && (!cfg_q[tlb_inval_pkg::NS_S2_POS] || mtag_q[g] == cmd_mtag) |=> !entry_valid[g])
         else $error("kernel entry survived invalidate all");

      hyp_all_a: assert property (cmd_valid && no_fill // see RULE_15
         && cmd_op == tlb_inval_pkg::hyp_inval_all_cmd && !illegal
         && (rg_q[g] == tlb_inval_pkg::regime_hyp
          || rg_q[g] == tlb_inval_pkg::regime_host_ext_hyp) |=> !entry_valid[g])
         else $error("hypervisor entry survived invalidate all");

      hx_addr_a: assert property (cmd_valid && no_fill && !illegal && host_ext // see RULE_18
         && cmd_op == tlb_inval_pkg::hyp_inval_addr_cmd
         && rg_q[g] == tlb_inval_pkg::regime_host_ext_hyp
         && page_q[g] == cmd_page && (!cmd_leaf || leaf_q[g])
         && (glb_q[g] || stag_q[g] == cmd_stag) |=> !entry_valid[g])
         else $error("host extended entry survived address invalidate");

      tag_spare_a: assert property (cmd_valid && no_fill && valid_q[g] // see RULE_22
         && cmd_op == tlb_inval_pkg::hyp_inval_by_tag_cmd
         && rg_q[g] == tlb_inval_pkg::regime_hyp |=> entry_valid[g])
         else $error("untagged hypervisor entry hit by tag");
   end

endmodule

/* sim/tlb_stage1_inval_tb_top.sv */
`timescale 1ns/100ps
module tlb_stage1_inval_tb_top;
   localparam logic [39:0] PAGE_A = 40'h0000123450;
   localparam logic [39:0] PAGE_B = 40'h0000abcde0;
   // Entry set: regime code, {machine tag, space tag}, global and leaf per index
   localparam logic [2:0]  fill_reg_tab [8] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4};
   localparam logic [7:0]  fill_tag_tab [8] = '{8'h15, 8'h16, 8'h25, 8'h15, 8'h26, 8'h05,
                                                8'h05, 8'h05};
   localparam logic [7:0]  fill_glob_mask   = 8'h11;
   localparam logic [7:0]  fill_leaf_mask   = 8'hed;

   logic                                      core_clk     = 1'b0;
   logic                                      sys_rst      = 1'b1;
   logic                                      wb_cyc_i     = 1'b0;
   logic                                      wb_stb_i     = 1'b0;
   logic                                      wb_we_i      = 1'b0;
   logic [7:0]                                wb_adr_i     = 8'h00;
   logic [3:0]                                wb_sel_i     = 4'h0;
   logic [31:0]                               wb_dat_i     = 32'h0;
   logic                                      wb_ack_o;
   logic [31:0]                               wb_dat_o;
   logic                                      cmd_valid    = 1'b0;
   tlb_inval_pkg::cmd_type                    cmd_op       = tlb_inval_pkg::kernel_inval_all_cmd;
   logic                                      cmd_secure   = 1'b0;
   logic [15:0]                               cmd_mtag     = 16'h0;
   logic [15:0]                               cmd_stag     = 16'h0;
   logic [39:0]                               cmd_page     = 40'h0;
   logic                                      cmd_leaf     = 1'b0;
   logic                                      cmd_done;
   logic                                      cmd_illegal;
   logic                                      fill_valid   = 1'b0;
   logic [2:0]                                fill_index   = 3'h0;
   tlb_inval_pkg::translation_regime_tag_type fill_regime  = tlb_inval_pkg::regime_ns_kernel;
   logic                                      fill_global  = 1'b0;
   logic [15:0]                               fill_mtag    = 16'h0;
   logic [15:0]                               fill_stag    = 16'h0;
   logic [39:0]                               fill_page    = 40'h0;
   logic                                      fill_leaf    = 1'b0;
   logic [7:0]                                entry_valid;
   logic [5:0]                                cfg_now      = 6'h22;
   int                                        fail_count   = 0;
   int                                        total_checks = 0;
   int                                        ill_total    = 0;

   always #2 core_clk = ~core_clk;

   tlb_stage1_inval dut_u (
      .core_clk    (core_clk),
      .sys_rst     (sys_rst),
      .wb_cyc_i    (wb_cyc_i),
      .wb_stb_i    (wb_stb_i),
      .wb_we_i     (wb_we_i),
      .wb_adr_i    (wb_adr_i),
      .wb_sel_i    (wb_sel_i),
      .wb_dat_i    (wb_dat_i),
      .wb_ack_o    (wb_ack_o),
      .wb_dat_o    (wb_dat_o),
      .cmd_valid   (cmd_valid),
      .cmd_op      (cmd_op),
      .cmd_secure  (cmd_secure),
      .cmd_mtag    (cmd_mtag),
      .cmd_stag    (cmd_stag),
      .cmd_page    (cmd_page),
      .cmd_leaf    (cmd_leaf),
      .cmd_done    (cmd_done),
      .cmd_illegal (cmd_illegal),
      .fill_valid  (fill_valid),
      .fill_index  (fill_index),
      .fill_regime (fill_regime),
      .fill_global (fill_global),
      .fill_mtag   (fill_mtag),
      .fill_stag   (fill_stag),
      .fill_page   (fill_page),
      .fill_leaf   (fill_leaf),
      .entry_valid (entry_valid)
   );

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Entered and left just after a rising edge; only the watchdog ends a wait for ack
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          output logic [31:0] rd);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= dat;
      do begin
         @(posedge core_clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge core_clk);
      check("wb_ack_drop", {31'h0, wb_ack_o}, 32'h0);
   endtask

   task automatic fill_all();
      for (int i = 0; i < 8; i++) begin
         fill_valid  <= 1'b1;
         fill_index  <= 3'(i);
         fill_regime <= tlb_inval_pkg::translation_regime_tag_type'(fill_reg_tab[i]);
         fill_global <= fill_glob_mask[i];
         fill_mtag   <= {12'h0, fill_tag_tab[i][7:4]};
         fill_stag   <= {12'h0, fill_tag_tab[i][3:0]};
         fill_page   <= PAGE_A;
         fill_leaf   <= fill_leaf_mask[i];
         @(posedge core_clk);
      end
      fill_valid <= 1'b0;
      @(posedge core_clk);
      check("refill", {24'h0, entry_valid}, 32'hff);
   endtask

   // Flags: [3] illegal expected, [2] secure queue, [1] second page, [0] leaf only
   task automatic run_case(input tlb_inval_pkg::cmd_type op, input logic [7:0] tags,
                           input logic [3:0] flags, input logic [7:0] hits);
      logic [31:0] rd;
      fill_all();
      // Host extension is written and settled before any command is queued
      wb_xfer(1'b1, tlb_inval_pkg::CFG_OFFSET, {26'h0, cfg_now}, rd);
      cmd_valid  <= 1'b1;
      cmd_op     <= op;
      cmd_secure <= flags[2];
      cmd_mtag   <= {12'h0, tags[7:4]};
      cmd_stag   <= {12'h0, tags[3:0]};
      cmd_page   <= flags[1] ? PAGE_B : PAGE_A;
      cmd_leaf   <= flags[0];
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      @(posedge core_clk);
      check("cmd_done", {31'h0, cmd_done}, 32'h1);
      check("cmd_illegal", {31'h0, cmd_illegal}, {31'h0, flags[3]});
      check("entry_valid", {24'h0, entry_valid}, {24'h0, ~hits});
      ill_total += flags[3];
      wb_xfer(1'b0, tlb_inval_pkg::STATUS_OFFSET, 32'h0, rd);
      check("status", rd, {16'h0, 8'($countones(~hits)), ill_total[7:0]});
   endtask

   task automatic reset_scn();
      logic [31:0] rd;
      check("entry_valid_rst", {24'h0, entry_valid}, 32'h0);
      wb_xfer(1'b0, tlb_inval_pkg::STATUS_OFFSET, 32'h0, rd);
      check("status_rst", rd, 32'h0);
      wb_xfer(1'b1, 8'h08, 32'hffffffff, rd);
      wb_xfer(1'b0, 8'h08, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      wb_xfer(1'b0, tlb_inval_pkg::CFG_OFFSET, 32'h0, rd);
      check("config_rst", rd, 32'h22);
   endtask

   task automatic kernel_all_scn();
      cfg_now = 6'h32;
      run_case(tlb_inval_pkg::kernel_inval_all_cmd, 8'h10, 4'h0, 8'h03);
      cfg_now = 6'h22;
      run_case(tlb_inval_pkg::kernel_inval_all_cmd, 8'h10, 4'h0, 8'h07);
      run_case(tlb_inval_pkg::kernel_inval_all_cmd, 8'h10, 4'h4, 8'h18);
      cfg_now = 6'h2a;
      run_case(tlb_inval_pkg::kernel_inval_all_cmd, 8'h10, 4'h4, 8'h08);
   endtask

   task automatic kernel_tag_scn();
      cfg_now = 6'h32;
      run_case(tlb_inval_pkg::kernel_inval_by_tag_cmd, 8'h16, 4'h0, 8'h02);
      cfg_now = 6'h22;
      run_case(tlb_inval_pkg::kernel_inval_by_tag_cmd, 8'h25, 4'h4, 8'h08);
      cfg_now = 6'h2a;
      run_case(tlb_inval_pkg::kernel_inval_by_tag_cmd, 8'h25, 4'h4, 8'h00);
   endtask

   task automatic kernel_addr_scn();
      cfg_now = 6'h32;
      run_case(tlb_inval_pkg::kernel_inval_addr_alltags_cmd, 8'h10, 4'h0, 8'h03);
      run_case(tlb_inval_pkg::kernel_inval_addr_alltags_cmd, 8'h10, 4'h2, 8'h00);
      run_case(tlb_inval_pkg::kernel_inval_addr_alltags_cmd, 8'h10, 4'h1, 8'h01);
      run_case(tlb_inval_pkg::kernel_inval_addr_cmd, 8'h15, 4'h0, 8'h01);
      cfg_now = 6'h22;
      run_case(tlb_inval_pkg::kernel_inval_addr_alltags_cmd, 8'h10, 4'h4, 8'h18);
      run_case(tlb_inval_pkg::kernel_inval_addr_cmd, 8'h15, 4'h4, 8'h18);
      run_case(tlb_inval_pkg::kernel_inval_addr_cmd, 8'h15, 4'h5, 8'h08);
      cfg_now = 6'h2a;
      run_case(tlb_inval_pkg::kernel_inval_addr_alltags_cmd, 8'h10, 4'h4, 8'h08);
      run_case(tlb_inval_pkg::kernel_inval_addr_cmd, 8'h15, 4'h4, 8'h08);
   endtask

   task automatic monitor_scn();
      cfg_now = 6'h22;
      run_case(tlb_inval_pkg::monitor_inval_all_cmd, 8'h00, 4'h4, 8'h80);
      run_case(tlb_inval_pkg::monitor_inval_addr_cmd, 8'h00, 4'h4, 8'h80);
      run_case(tlb_inval_pkg::monitor_inval_addr_cmd, 8'h00, 4'h6, 8'h00);
      run_case(tlb_inval_pkg::monitor_inval_all_cmd, 8'h00, 4'h8, 8'h00);
      run_case(tlb_inval_pkg::monitor_inval_addr_cmd, 8'h00, 4'h8, 8'h00);
      cfg_now = 6'h26;
      run_case(tlb_inval_pkg::monitor_inval_all_cmd, 8'h00, 4'hc, 8'h00);
      run_case(tlb_inval_pkg::monitor_inval_addr_cmd, 8'h00, 4'hc, 8'h00);
   endtask

   task automatic hyp_scn();
      cfg_now = 6'h22;
      run_case(tlb_inval_pkg::hyp_inval_all_cmd, 8'h00, 4'h0, 8'h60);
      run_case(tlb_inval_pkg::hyp_inval_all_cmd, 8'h00, 4'h4, 8'h60);
      run_case(tlb_inval_pkg::hyp_inval_addr_cmd, 8'h09, 4'h0, 8'h20);
      run_case(tlb_inval_pkg::hyp_inval_addr_alltags_cmd, 8'h00, 4'h0, 8'h20);
      cfg_now = 6'h23;
      run_case(tlb_inval_pkg::hyp_inval_addr_cmd, 8'h05, 4'h0, 8'h40);
      run_case(tlb_inval_pkg::hyp_inval_addr_cmd, 8'h09, 4'h0, 8'h00);
      run_case(tlb_inval_pkg::hyp_inval_addr_cmd, 8'h05, 4'h4, 8'h40);
      run_case(tlb_inval_pkg::hyp_inval_addr_alltags_cmd, 8'h00, 4'h0, 8'h40);
      run_case(tlb_inval_pkg::hyp_inval_by_tag_cmd, 8'h05, 4'h0, 8'h40);
   endtask

   task automatic illegal_scn();
      cfg_now = 6'h20;
      for (int i = 6; i < 10; i++) begin
         run_case(tlb_inval_pkg::cmd_type'(4'(i)), 8'h05, 4'hc, 8'h00);
      end
      cfg_now = 6'h02;
      for (int i = 0; i < 10; i++) begin
         run_case(tlb_inval_pkg::cmd_type'(4'(i)), 8'h05, 4'hc, 8'h00);
      end
      cfg_now = 6'h22;
      run_case(tlb_inval_pkg::cmd_type'(4'ha), 8'h05, 4'hc, 8'h00);
   endtask

   initial begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      reset_scn();
      kernel_all_scn();
      kernel_tag_scn();
      kernel_addr_scn();
      monitor_scn();
      hyp_scn();
      illegal_scn();
      give_verdict();
   end

   // 47 cases of about 20 cycles each; a wide margin before giving up
   initial begin
      repeat (6000) @(posedge core_clk);
      fail_count++;
      give_verdict();
   end
endmodule
